// ===== shared/dipg_pkg.sv
/*
 * Shared constants and carrier types for the disk interface port glue.
 * Assumes an 8-bit processor bus sampled synchronously to clk_i.
 */
package dipg_pkg;

	// ------------------------------------------------------------
	// I/O port ranges (low address byte)
	// ------------------------------------------------------------
	localparam logic [7:0] PRN_LO = 8'h20;
	localparam logic [7:0] PRN_HI = 8'h2f;
	localparam logic [7:0] DRV_LO = 8'h30;
	localparam logic [7:0] DRV_HI = 8'h3f;
	localparam logic [7:0] FDC_LO = 8'h40;
	localparam logic [7:0] FDC_HI = 8'h4f;
	localparam logic [7:0] MISC_LO = 8'h50;
	localparam logic [7:0] MISC_HI = 8'h5f;
	localparam logic [7:0] HOST_LO = 8'h70;
	localparam logic [7:0] HOST_HI = 8'h7f;
	localparam logic [7:0] CTC_LO = 8'h80;
	localparam logic [7:0] CTC_HI = 8'hbf;

	// ------------------------------------------------------------
	// Single-bit latch positions (address bits 2:0)
	// ------------------------------------------------------------
	localparam int unsigned ML_HOST_RX = 0;
	localparam int unsigned ML_RS_TX = 1;
	localparam int unsigned ML_ROM_OFF = 2;
	localparam int unsigned ML_STROBE = 3;
	localparam int unsigned ML_IDX_CLR = 4;
	localparam int unsigned ML_RS_CTL = 5;
	localparam int unsigned ML_IDX_PRE = 6;
	localparam int unsigned ML_TRIG_SEL = 7;

	// Lines idle high, ROM on, strobe low, index clear/preset released
	localparam logic [7:0] MISC_RESET = 8'h53;
	localparam logic [7:0] DRV_RESET = 8'h00;
	localparam logic [7:0] PRN_RESET = 8'h00;
	localparam logic IDX_EN_RESET = 1'b1;

	// ------------------------------------------------------------
	// Drive control field positions
	// ------------------------------------------------------------
	localparam int unsigned DC_FM = 7;
	localparam int unsigned DC_SLOW = 6;
	localparam int unsigned DC_SIDE = 5;
	localparam int unsigned DC_FDC_RST = 4;

	// Boot ROM window: lower 32K, 4K decode (2K parts mirror too)
	localparam int unsigned ROM_AW = 12;

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic mreq_n;
		logic iorq_n;
		logic rd_n;
		logic wr_n;
		logic halt_n;
	} dipg_bus_t;

	typedef struct packed {
		logic density_fm;
		logic clk_slow;
		logic side;
		logic fdc_reset;
		logic [3:0] select;
	} dipg_drive_t;

	typedef struct packed {
		logic rom_cs_n;
		logic ram_cs_n;
		logic ram_we_n;
		logic [ROM_AW-1:0] rom_addr;
	} dipg_mem_t;

endpackage

// ===== rtl/dipg_top.sv
/*
 * Port decode and glue logic of a disk interface box: boot ROM overlay,
 * drive control latch, single-bit control latches, status input ports,
 * controller interrupt gating and counter/timer routing.
 * Assumes all processor bus and pin inputs are synchronous to clk_i; the
 * floppy controller and counter/timer chips sit outside and are reached
 * through the chip selects and routed signals below.
 */
module dipg_top
	import dipg_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Processor bus
	input wire dipg_bus_t bus_i,
	output logic [7:0] rdata_o,
	output logic rdata_oen_o,
	output logic nmi_n_o,
	output logic int_n_o,
	// Memory selects
	output dipg_mem_t mem_o,
	// Peripheral chip selects
	output logic fdc_cs_n_o,
	output logic ctc_cs_n_o,
	// Floppy controller and drives
	input wire logic fdc_data_request_i,
	input wire logic fdc_completion_request_i,
	input wire logic fdc_head_load_i,
	input wire logic index_sensor_i,
	output dipg_drive_t drive_o,
	output logic fdc_index_o,
	output logic motor_on_o,
	// Counter/timer unit
	input wire logic ctc_ch2_out_i,
	input wire logic ctc_int_n_i,
	output logic ctc_trig0_o,
	output logic ctc_ch3_clk_o,
	// Host serial bus
	input wire logic host_transmit_line_i,
	input wire logic command_frame_line_i,
	input wire logic host_power_sense_i,
	output logic host_receive_line_o,
	// Printer
	input wire logic prn_busy_i,
	input wire logic prn_error_i,
	input wire logic prn_ack_i,
	output logic [7:0] prn_data_o,
	output logic prn_strobe_o,
	// RS-232
	input wire logic rs_rx_i,
	input wire logic rs_ri_i,
	input wire logic rs_modem_i,
	output logic rs_tx_o,
	output logic rs_ctl_o
);

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic logic in_rng(input logic [7:0] a,
		input logic [7:0] lo, input logic [7:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0] misc_q;
	logic [7:0] misc_d;
	logic [7:0] drv_q;
	logic [7:0] drv_d;
	logic [7:0] prn_q;
	logic [7:0] prn_d;
	logic idx_en_q;
	logic idx_en_d;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire logic [7:0] pa = bus_i.addr[7:0];
	wire logic io_cyc = !bus_i.iorq_n;
	wire logic io_wr = io_cyc && !bus_i.wr_n;
	wire logic io_rd = io_cyc && !bus_i.rd_n;
	wire logic mem_cyc = !bus_i.mreq_n;
	wire logic mem_wr = mem_cyc && !bus_i.wr_n;
	wire logic mem_rd = mem_cyc && !bus_i.rd_n;

	wire logic sel_prn = in_rng(pa, PRN_LO, PRN_HI);
	wire logic sel_drv = in_rng(pa, DRV_LO, DRV_HI);
	wire logic sel_fdc = in_rng(pa, FDC_LO, FDC_HI);
	wire logic sel_misc = in_rng(pa, MISC_LO, MISC_HI);
	wire logic sel_host = in_rng(pa, HOST_LO, HOST_HI);
	wire logic sel_ctc = in_rng(pa, CTC_LO, CTC_HI);

	// ------------------------------------------------------------
	// Memory overlay
	// ------------------------------------------------------------
	wire logic rom_on = !misc_q[ML_ROM_OFF];
	wire logic low_half = !bus_i.addr[15];
	// Only reads are diverted; upper address bits ignored to mirror
	wire logic rom_rd = mem_rd && low_half && rom_on;
	// Writes bypass the overlay so RAM can be loaded beneath the ROM
	wire logic ram_sel = mem_wr || (mem_rd && !rom_rd);
	dipg_mem_t mem_d;
	assign mem_d.rom_cs_n = !rom_rd;
	assign mem_d.ram_cs_n = !ram_sel;
	assign mem_d.ram_we_n = !mem_wr;
	assign mem_d.rom_addr = bus_i.addr[ROM_AW-1:0];

	// ------------------------------------------------------------
	// Write latches
	// ------------------------------------------------------------
	// Unconnected ranges match none of these, so writes there vanish
	wire logic wr_prn = io_wr && sel_prn;
	wire logic wr_drv = io_wr && sel_drv;
	wire logic wr_misc = io_wr && sel_misc;

	assign prn_d = wr_prn ? bus_i.wdata : prn_q;
	assign drv_d = wr_drv ? bus_i.wdata : drv_q;

	always_comb begin
		misc_d = misc_q;
		if (wr_misc) begin
			misc_d[pa[2:0]] = bus_i.wdata[0];
		end
	end

	// Clear has priority if software asserts both at once
	always_comb begin
		idx_en_d = idx_en_q;
		if (!misc_q[ML_IDX_CLR]) begin
			idx_en_d = 1'b0;
		end else if (!misc_q[ML_IDX_PRE]) begin
			idx_en_d = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Status read mux
	// ------------------------------------------------------------
	wire logic [7:0] prn_st = {prn_busy_i, prn_error_i, !prn_busy_i,
		!prn_ack_i, 4'h0};
	wire logic [7:0] rs_st = {rs_rx_i, 4'h0, rs_ri_i, rs_modem_i,
		1'b0};
	wire logic [7:0] host_st = {host_transmit_line_i, 3'h0,
		host_power_sense_i, 1'b0, command_frame_line_i,
		1'b0};
	// Only glue-owned status ports are driven; elsewhere the bus floats
	wire logic rd_own = io_rd && (sel_prn || sel_misc || sel_host);
	wire logic [7:0] rd_mux = sel_prn ? prn_st :
		sel_misc ? rs_st :
		sel_host ? host_st : 8'h00;

	// ------------------------------------------------------------
	// Routed and derived signals
	// ------------------------------------------------------------
	// Sensor can only be masked; there is no software pulse source
	wire logic idx_d = index_sensor_i && idx_en_q;
	wire logic fdc_req = fdc_data_request_i || fdc_completion_request_i;
	wire logic nmi_d = !bus_i.halt_n && fdc_req;
	wire logic trig_d = misc_q[ML_TRIG_SEL] ? command_frame_line_i :
		host_transmit_line_i;
	dipg_drive_t drive_d;
	assign drive_d.density_fm = drv_q[DC_FM];
	assign drive_d.clk_slow = drv_q[DC_SLOW];
	assign drive_d.side = drv_q[DC_SIDE];
	assign drive_d.fdc_reset = drv_q[DC_FDC_RST];
	assign drive_d.select = drv_q[3:0];

	// ------------------------------------------------------------
	// Latch registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			misc_q <= MISC_RESET;
			drv_q <= DRV_RESET;
			prn_q <= PRN_RESET;
			idx_en_q <= IDX_EN_RESET;
		end else begin
			misc_q <= misc_d;
			drv_q <= drv_d;
			prn_q <= prn_d;
			idx_en_q <= idx_en_d;
		end
	end

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------
	// Registering adds one cycle of latency to every output; the
	// processor bus runs far slower than clk_i, so this is harmless.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_o <= 8'h00;
			rdata_oen_o <= 1'b1;
			mem_o <= '{rom_cs_n: 1'b1, ram_cs_n: 1'b1,
				ram_we_n: 1'b1, rom_addr: '0};
			fdc_cs_n_o <= 1'b1;
			ctc_cs_n_o <= 1'b1;
		end else begin
			rdata_o <= rd_mux;
			rdata_oen_o <= !rd_own;
			mem_o <= mem_d;
			fdc_cs_n_o <= !(io_cyc && sel_fdc);
			ctc_cs_n_o <= !(io_cyc && sel_ctc);
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			nmi_n_o <= 1'b1;
			int_n_o <= 1'b1;
			drive_o <= '0;
			fdc_index_o <= 1'b0;
			motor_on_o <= 1'b0;
			ctc_trig0_o <= 1'b0;
			ctc_ch3_clk_o <= 1'b0;
		end else begin
			nmi_n_o <= !nmi_d;
			int_n_o <= ctc_int_n_i;
			drive_o <= drive_d;
			fdc_index_o <= idx_d;
			motor_on_o <= fdc_head_load_i;
			ctc_trig0_o <= trig_d;
			ctc_ch3_clk_o <= ctc_ch2_out_i;
		end
	end

	// No proceed, interrupt or clock line outputs exist toward the host
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			host_receive_line_o <= 1'b1;
			prn_data_o <= 8'h00;
			prn_strobe_o <= 1'b0;
			rs_tx_o <= 1'b1;
			rs_ctl_o <= 1'b0;
		end else begin
			host_receive_line_o <= misc_q[ML_HOST_RX];
			prn_data_o <= prn_q;
			prn_strobe_o <= misc_q[ML_STROBE];
			rs_tx_o <= misc_q[ML_RS_TX];
			rs_ctl_o <= misc_q[ML_RS_CTL];
		end
	end

endmodule

// ===== dv/dipg_props.sv
/* Checker for the port glue: memory decode, status, interrupt, index.
   Sees only the top module ports; bound to every top instance. */
module dipg_props
	import dipg_pkg::*;
(
	// Clock and processor bus
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire dipg_bus_t bus_i,
	input wire logic [7:0] rdata_o,
	input wire logic rdata_oen_o,
	input wire dipg_mem_t mem_o,
	// Controller, drive and host pins
	input wire logic nmi_n_o,
	input wire logic fdc_data_request_i,
	input wire logic fdc_completion_request_i,
	input wire logic fdc_head_load_i,
	input wire logic motor_on_o,
	input wire logic index_sensor_i,
	input wire logic fdc_index_o,
	input wire logic host_transmit_line_i,
	input wire logic command_frame_line_i,
	input wire logic host_power_sense_i
);
	timeunit 1ns;
	timeprecision 1ps;
	wire io_rd = !bus_i.iorq_n && !bus_i.rd_n;
	wire mem_rd = !bus_i.mreq_n && !bus_i.rd_n;
	wire mem_wr = !bus_i.mreq_n && !bus_i.wr_n;
	wire fdc_rq = fdc_data_request_i || fdc_completion_request_i;
	wire [3:0] io_pg = bus_i.addr[7:4];
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	property p_nmi_halt; !bus_i.halt_n && fdc_rq |=> !nmi_n_o; endproperty
	a_nmi_halt: assert property (p_nmi_halt)
		else $error("nmi missing while halted");
	property p_nmi_run; bus_i.halt_n |=> nmi_n_o; endproperty
	a_nmi_run: assert property (p_nmi_run)
		else $error("nmi raised while running");
	property p_ram_wr;
		mem_wr |=> !mem_o.ram_cs_n && !mem_o.ram_we_n && mem_o.rom_cs_n;
	endproperty
	a_ram_wr: assert property (p_ram_wr)
		else $error("memory write missed ram");
	property p_rom_addr; mem_rd && !bus_i.addr[15] ##1 !mem_o.rom_cs_n
		|-> mem_o.rom_addr == $past(bus_i.addr[11:0]); endproperty
	a_rom_addr: assert property (p_rom_addr)
		else $error("rom address not mirrored");
	property p_host_st; io_rd && io_pg == 4'h7 |=> !rdata_oen_o &&
		rdata_o == {$past(host_transmit_line_i), 3'h0,
		$past(host_power_sense_i), 1'h0, $past(command_frame_line_i), 1'h0};
	endproperty
	a_host_st: assert property (p_host_st)
		else $error("host status read wrong");
	property p_unconn; io_rd && io_pg < 4'h2 |=> rdata_oen_o; endproperty
	a_unconn: assert property (p_unconn)
		else $error("unconnected port drove data");
	property p_index; fdc_index_o |-> $past(index_sensor_i); endproperty
	a_index: assert property (p_index)
		else $error("index pulse without sensor");
	property p_motor; fdc_head_load_i [*2] |-> motor_on_o; endproperty
	a_motor: assert property (p_motor)
		else $error("motor not following head load");
	c_nmi: cover property (!nmi_n_o);
	c_rom: cover property (!mem_o.rom_cs_n);
	c_idx: cover property (fdc_index_o);
endmodule

bind dipg_top dipg_props i_props (.clk_i(clk_i), .resetn_i(resetn_i),
	.bus_i(bus_i), .rdata_o(rdata_o), .rdata_oen_o(rdata_oen_o),
	.mem_o(mem_o), .nmi_n_o(nmi_n_o), .fdc_data_request_i(fdc_data_request_i),
	.fdc_completion_request_i(fdc_completion_request_i),
	.fdc_head_load_i(fdc_head_load_i), .motor_on_o(motor_on_o),
	.index_sensor_i(index_sensor_i), .fdc_index_o(fdc_index_o),
	.host_transmit_line_i(host_transmit_line_i),
	.command_frame_line_i(command_frame_line_i),
	.host_power_sense_i(host_power_sense_i));

// ===== dv/dipg_host_model.sv
/* Host computer on the serial peripheral bus.
   Assumes the bench asks for line levels; they reach the wire a clock later. */
module dipg_host_model (
	// Requests from the bench
	input wire logic clk_i,
	input wire logic tx_bit_i,
	input wire logic cmd_bit_i,
	input wire logic pwr_i,
	// Lines toward the drive
	output logic transmit_line_o,
	output logic command_frame_n_o,
	output logic power_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Frame line is active low on the wire
	always_ff @(posedge clk_i) begin
		transmit_line_o <= tx_bit_i;
		command_frame_n_o <= !cmd_bit_i;
		power_o <= pwr_i;
	end
endmodule

// ===== dv/disk_interface_port_glue_tb_top.sv
/* Bench for the port glue: a table of latch writes, then hand tests.
   Assumes the host model and the 50 MHz clock made here. */
module disk_interface_port_glue_tb_top
	import dipg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [7:0] port;
		logic [7:0] data;
		logic [7:0] exp_v;
	} dipg_row_t;
	logic clk_i, resetn_i, fdc_data_request, fdc_completion_request, head, sensor, ch2, cint_n;
	logic tx_bit, cmd_bit, pwr, busy, err, ack, rx, ri, modem;
	logic tx_line, cmd_line, pwr_line, oen, nmi_n, int_n, idx, motor;
	logic trig0, ch3_clk, host_rx, strobe, rs_tx, rs_ctl;
	logic [7:0] rdata, prn_data;
	dipg_bus_t bus;
	dipg_mem_t mem;
	dipg_drive_t drive;
	int num_errors = 0;
	int samples_checked = 0;
	wire logic [7:0] misc_v = {2'h0, rs_ctl, 1'h0, strobe, 1'h0, rs_tx, host_rx};
	dipg_row_t rows[17] = '{'{8'h30, 8'ha5, 8'ha5}, '{8'h3f, 8'h0f, 8'h0f},
		'{8'h6f, 8'hff, 8'h0f}, '{8'h7c, 8'hff, 8'h0f}, '{8'h0a, 8'hff, 8'h0f},
		'{8'h35, 8'h00, 8'h00}, '{8'h3a, 8'h40, 8'h40}, '{8'h3b, 8'h80, 8'h80},
		'{8'h20, 8'h3c, 8'h3c}, '{8'h2f, 8'hc3, 8'hc3}, '{8'h50, 8'h00, 8'h00},
		'{8'h58, 8'hff, 8'h01}, '{8'h51, 8'hfe, 8'h00}, '{8'h59, 8'h01, 8'h01},
		'{8'h53, 8'h01, 8'h01}, '{8'h5b, 8'h00, 8'h00}, '{8'h55, 8'h01, 8'h01}};
	dipg_host_model i_host (.clk_i(clk_i), .tx_bit_i(tx_bit),
		.cmd_bit_i(cmd_bit), .pwr_i(pwr), .transmit_line_o(tx_line),
		.command_frame_n_o(cmd_line), .power_o(pwr_line));
	dipg_top i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus),
		.rdata_o(rdata), .rdata_oen_o(oen), .nmi_n_o(nmi_n), .int_n_o(int_n),
		.mem_o(mem), .fdc_cs_n_o(), .ctc_cs_n_o(), .fdc_data_request_i(fdc_data_request),
		.fdc_completion_request_i(fdc_completion_request), .fdc_head_load_i(head),
		.index_sensor_i(sensor), .drive_o(drive), .fdc_index_o(idx),
		.motor_on_o(motor), .ctc_ch2_out_i(ch2), .ctc_int_n_i(cint_n),
		.ctc_trig0_o(trig0), .ctc_ch3_clk_o(ch3_clk),
		.host_transmit_line_i(tx_line), .command_frame_line_i(cmd_line),
		.host_power_sense_i(pwr_line), .host_receive_line_o(host_rx),
		.prn_busy_i(busy), .prn_error_i(err), .prn_ack_i(ack),
		.prn_data_o(prn_data), .prn_strobe_o(strobe), .rs_rx_i(rx),
		.rs_ri_i(ri), .rs_modem_i(modem), .rs_tx_o(rs_tx), .rs_ctl_o(rs_ctl));
	// ----
	// Bus tasks
	// ----
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		step(1);
		bus.addr = {8'h00, a};
		bus.wdata = d;
		bus[4:1] = 4'ha;
		step(1);
		bus[4:1] = 4'hf;
		step(2);
	endtask
	task automatic rd_t(input logic [7:0] a, input logic [7:0] e,
		input logic oe);
		step(1);
		bus.addr = {8'h00, a};
		bus[4:1] = 4'h9;
		step(1);
		if (oe) chk(16'(oen), 16'h0001);
		else chk({7'h00, rdata, oen}, {7'h00, e, 1'h0});
		bus[4:1] = 4'hf;
	endtask
	task automatic mem_t(input logic [15:0] a, input logic w,
		input logic [15:0] e);
		step(1);
		bus.addr = a;
		bus.mreq_n = 1'h0;
		bus.wr_n = !w;
		bus.rd_n = w;
		step(1);
		chk({1'h0, mem}, e);
		bus[4:1] = 4'hf;
	endtask
	function automatic logic [7:0] obs(input logic [7:0] p);
		if (p[7:4] == 4'h2) return prn_data;
		if (p[7:4] == 4'h5) return {7'h00, misc_v[p[2:0]]};
		return drive;
	endfunction
	task automatic give_verdict;
		$display("errors %0d, checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		clk_i = 1'h0;
		forever #10 clk_i = ~clk_i;
	end
	initial begin
		#100000;
		num_errors++;
		give_verdict();
	end
	initial begin
		bus = '0;
		bus[4:0] = 5'h1f;
		{fdc_data_request, fdc_completion_request, head, sensor, ch2, cmd_bit, ack, modem} = 8'h15;
		{cint_n, tx_bit, pwr, busy, err, rx, ri} = 7'h7f;
		resetn_i = 1'h0;
		step(3);
		resetn_i = 1'h1;
		foreach (rows[i]) begin
			wr(rows[i].port, rows[i].data);
			chk(16'(obs(rows[i].port)), 16'(rows[i].exp_v));
		end
		mem_t(16'h1234, 1'h0, 16'h3234);
		mem_t(16'h7abc, 1'h0, 16'h3abc);
		mem_t(16'h9abc, 1'h0, 16'h5abc);
		mem_t(16'h0100, 1'h1, 16'h4100);
		wr(8'h52, 8'h01);
		mem_t(16'h0100, 1'h0, 16'h5100);
		mem_t(16'h0100, 1'h1, 16'h4100);
		wr(8'h5a, 8'h00);
		mem_t(16'h0100, 1'h0, 16'h3100);
		wr(8'h54, 8'h00);
		step(1);
		chk(16'(idx), 16'h0000);
		wr(8'h54, 8'h01);
		wr(8'h5e, 8'h00);
		step(1);
		chk(16'(idx), 16'h0001);
		sensor = 1'h0;
		step(2);
		chk(16'(idx), 16'h0000);
		wr(8'h57, 8'h00);
		chk(16'(trig0), 16'h0001);
		wr(8'h5f, 8'h01);
		chk(16'(trig0), 16'h0000);
		rd_t(8'h7b, 8'h88, 1'h0);
		rd_t(8'h2a, 8'hd0, 1'h0);
		rd_t(8'h5c, 8'h86, 1'h0);
		rd_t(8'h33, 8'h00, 1'h1);
		rd_t(8'hc4, 8'h00, 1'h1);
		{rx, ri, modem, pwr, cmd_bit} = 5'h04;
		step(3);
		rd_t(8'h50, 8'h02, 1'h0);
		rd_t(8'h70, 8'h82, 1'h0);
		bus.halt_n = 1'h0;
		step(2);
		chk(16'(nmi_n), 16'h0001);
		{fdc_data_request, fdc_completion_request} = 2'h1;
		step(2);
		chk(16'(nmi_n), 16'h0000);
		bus.halt_n = 1'h1;
		step(2);
		chk(16'(nmi_n), 16'h0001);
		{head, ch2, cint_n} = 3'h6;
		step(2);
		chk(16'({motor, ch3_clk, int_n}), 16'h0006);
		wr(8'h52, 8'h01);
		resetn_i = 1'h0;
		step(2);
		resetn_i = 1'h1;
		mem_t(16'h0042, 1'h0, 16'h3042);
		give_verdict();
	end
endmodule
